// file: host_bus.sv
// host processor model driving the channel bus
`timescale 1ns/1ns
module host_bus (
  // clock
  input wire logic mclk,
  // bus
  output logic chan_sel_n = 1'b1,
  output logic [2:0] addr = 3'h0,
  output logic rd_stb = 1'b0,
  output logic wr_stb = 1'b0,
  output logic [7:0] wr_data = 8'h00,
  input wire logic [7:0] rd_data
);
  task automatic xfer(input logic sel_n, input logic wr,
      input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    #1;
    chan_sel_n = sel_n;
    addr = a;
    wr_data = wr ? d : ~d;
    wr_stb = wr;
    rd_stb = !wr;
    @(posedge mclk);
    #1;
    // released lines show inverse values
    chan_sel_n = 1'b1;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    addr = ~a;
    wr_data = ~wr_data;
    @(posedge mclk);
    #1;
    q = rd_data;
  endtask
endmodule

// file: loop_serial.sv
// minimal 8n1 shifter pair with loopback path selection
`timescale 1ns/1ns
module loop_serial #(
  parameter int DIV_W = 16
) (
  // clock
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // control
  input wire logic loop_en,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  input wire logic rx_pin_sync,
  // status
  output logic tx_busy,
  output logic tx_line,
  output logic rx_done,
  output logic rx_brk,
  output logic [7:0] rx_byte
);
  // refused at elaboration, not at run time
  if (DIV_W < 2) begin
    $error("DIV_W too small");
  end
  logic [DIV_W-1:0] tcnt_r, rcnt_r;
  logic [3:0] tbit_r, rbit_r;
  logic [8:0] tsh_r, rsh_r;
  logic rx_in;
  // shift output feeds receive input in loopback
  assign rx_in = loop_en ? tsh_r[0] : rx_pin_sync; // [RULE2]
  assign tx_line = tsh_r[0];
  assign tx_busy = tbit_r != 4'h0;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tsh_r <= 9'h1FF;
      tbit_r <= 4'h0;
      tcnt_r <= '0;
    end else if (clk_en) begin
      if (tbit_r == 4'h0) begin
        if (tx_load) begin
          tsh_r <= {tx_byte, 1'b0};
          tbit_r <= regsel_pkg::BIT_FRAME;
          tcnt_r <= divisor;
        end
      end else if (tcnt_r <= 1) begin
        tcnt_r <= divisor;
        tsh_r <= {1'b1, tsh_r[8:1]};
        tbit_r <= tbit_r - 4'h1;
      end else begin
        tcnt_r <= tcnt_r - 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsh_r <= '0;
      rbit_r <= 4'h0;
      rcnt_r <= '0;
      rx_done <= 1'b0;
      rx_brk <= 1'b0;
      rx_byte <= 8'h00;
    end else if (clk_en) begin
      rx_done <= 1'b0;
      rx_brk <= 1'b0;
      if (rbit_r == 4'h0) begin
        if (!rx_in) begin
          // start bit not shifted in: eight data samples, then stop
          rbit_r <= regsel_pkg::BIT_FRAME - 4'h1;
          rcnt_r <= divisor + (divisor >> 1);
        end
      end else if (rcnt_r <= 1) begin
        rcnt_r <= divisor;
        rbit_r <= rbit_r - 4'h1;
        rsh_r <= {rx_in, rsh_r[8:1]};
        if (rbit_r == 4'h1) begin
          rx_byte <= rsh_r[8:1];
          rx_done <= 1'b1;
          rx_brk <= !rx_in && (rsh_r[8:1] == 8'h00);
        end
      end else begin
        rcnt_r <= rcnt_r - 1'b1;
      end
    end
  end
endmodule

// file: regsel_pkg.sv
// constants for the uart channel register select and loopback block
package regsel_pkg;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IEN = 3'h1;
  localparam logic [2:0] ADDR_ISTAT = 3'h2;
  localparam logic [2:0] ADDR_LCTL = 3'h3;
  localparam logic [2:0] ADDR_MCTL = 3'h4;
  localparam logic [2:0] ADDR_LSTAT = 3'h5;
  localparam logic [2:0] ADDR_MSTAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;
  localparam logic [7:0] ENH_KEY = 8'hBF;
  localparam int LCTL_DIV_BIT = 7;
  localparam int MCTL_LOOP_BIT = 4;
  localparam int MCTL_OUT2_BIT = 3;
  localparam int MCTL_OUT1_BIT = 2;
  localparam int MCTL_RTS_BIT = 1;
  localparam int MCTL_DTR_BIT = 0;
  localparam int EFUNC_ENH_BIT = 4;
  localparam int FCTL_SEL_BIT = 6;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] LCTL_RESET = 8'h00;
  localparam logic [7:0] LSTAT_RESET = 8'h60;
  localparam logic [7:0] ISTAT_IDLE = 8'h01;
  localparam int LSTAT_READY_BIT = 0;
  localparam int LSTAT_BREAK_BIT = 4;
  localparam int LSTAT_THRE_BIT = 5;
  localparam int LSTAT_TEMT_BIT = 6;
  localparam logic TX_IDLE = 1'b1;
  localparam logic MODEM_OUT_IDLE_N = 1'b1;
  localparam logic [3:0] BIT_FRAME = 4'hA;
endpackage

// file: regsel_props.sv
// checker for register select and loopback of one channel
`timescale 1ns/1ns
module regsel_props (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // host bus
  input wire logic chan_sel_n,
  input wire logic [2:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  // pins
  input wire logic tx_pin,
  input wire logic rts_out_n,
  input wire logic dtr_out_n,
  input wire logic loop_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0] lc_r, mc_r;
  logic [7:0] ch_r [4];
  logic [3:0] v_r, age_r;
  wire wr = clk_en && !chan_sel_n && wr_stb;
  wire rd = clk_en && !chan_sel_n && rd_stb;
  wire key = lc_r == regsel_pkg::ENH_KEY;
  wire [3:0] ms = {mc_r[3], mc_r[2], mc_r[0], mc_r[1]};
  wire [7:0] chv = ch_r[addr[1:0]];
  always_ff @(posedge mclk) begin
    if (sys_rst) lc_r <= regsel_pkg::LCTL_RESET;
    else if (wr && addr == 3'h3) lc_r <= wr_data;
  end
  // cycles since the last modem control write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      age_r <= 4'h0;
      mc_r <= 8'h00;
    end else if (wr && addr == 3'h4 && !key) begin
      age_r <= 4'h0;
      mc_r <= wr_data;
    end else if (age_r != 4'hF) begin
      age_r <= age_r + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      v_r <= 4'h0;
    end else if (wr && key && addr[2]) begin
      ch_r[addr[1:0]] <= wr_data;
      v_r[addr[1:0]] <= 1'b1;
    end
  end
  property p_loop_on;
    wr && addr == 3'h4 && !key && wr_data[4] |-> ##[1:2] loop_active;
  endproperty
  a_loop_on: assert property (p_loop_on)
    else $error("loopback not entered");
  property p_loop_off;
    wr && addr == 3'h4 && !key && !wr_data[4] |-> ##[1:2] !loop_active;
  endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loopback not left");
  property p_held;
    loop_active && $past(loop_active) |-> tx_pin == regsel_pkg::TX_IDLE
      && {rts_out_n, dtr_out_n} == {2{regsel_pkg::MODEM_OUT_IDLE_N}};
  endproperty
  a_held: assert property (p_held)
    else $error("pins not held in loopback");
  property p_loop_mstat;
    rd && addr == 3'h6 && !key && loop_active && age_r > 4'h4
      |=> rd_data[7:4] == $past(ms);
  endproperty
  a_loop_mstat: assert property (p_loop_mstat)
    else $error("loopback modem status wrong");
  property p_lc_rd;
    rd && addr == 3'h3 |=> rd_data == $past(lc_r);
  endproperty
  a_lc_rd: assert property (p_lc_rd)
    else $error("line control readback wrong");
  property p_rd_hold;
    !rd |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  property p_wr_ign;
    chan_sel_n && wr_stb |=> $stable(loop_active);
  endproperty
  a_wr_ign: assert property (p_wr_ign)
    else $error("unselected write took effect");
  property p_key_chr;
    rd && key && addr[2] && v_r[addr[1:0]] |=> rd_data == $past(chv);
  endproperty
  a_key_chr: assert property (p_key_chr)
    else $error("flow character readback wrong");
  property p_key_mc;
    wr && key && addr == 3'h4 |=> $stable(loop_active);
  endproperty
  a_key_mc: assert property (p_key_mc)
    else $error("key write reached modem control");
endmodule

// file: uart_register_select_loopback_tb.sv
// testbench for the channel register select and loopback block
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
  end \
end
module uart_register_select_loopback_tb;
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  localparam logic [7:0] DID = 8'hC3; // arbitrary value
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic rx_pin = 1'b1;
  logic [3:0] mi_n = 4'hF;
  logic chan_sel_n, rd_stb, wr_stb, tx_pin, rts_out_n, dtr_out_n, loop_active;
  logic op2_out_n;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, q;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int m [string];
  int sent [$];
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  host_bus u_host_bus (.mclk(mclk), .chan_sel_n(chan_sel_n), .addr(addr),
    .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data));
  uart_regsel #(.REVISION(REV), .DEVICE_ID(DID)) u_uart_regsel (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .chan_sel_n(chan_sel_n),
    .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_data(rd_data), .rx_pin(rx_pin), .cts_in_n(mi_n[0]),
    .dsr_in_n(mi_n[1]), .carrier_detect_in_n(mi_n[2]),
    .ring_indicator_in_n(mi_n[3]), .tx_pin(tx_pin), .rts_out_n(rts_out_n),
    .dtr_out_n(dtr_out_n), .op2_out_n(op2_out_n), .loop_active(loop_active));
  task automatic wr(input logic [2:0] a, input int d);
    u_host_bus.xfer(1'b0, 1'b1, a, d[7:0], q);
  endtask
  task automatic rdc(input string n, input logic [2:0] a, input int e);
    u_host_bus.xfer(1'b0, 1'b0, a, 8'h00, q);
    `CHK(n, e[7:0], q)
  endtask
  task automatic wait_line(input int b);
    for (int i = 0; i < 100; i++) begin
      u_host_bus.xfer(1'b0, 1'b0, 3'h5, 8'h00, q);
      if (q[b] === 1'b1) break;
    end
    `CHK("line status", 1'b1, q[b])
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(51));
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    wr(3'h3, 8'h03);
    for (int i = 0; i < 4; i++) begin
      m["ien"] = $urandom % 256;
      m["scr"] = $urandom % 256;
      wr(3'h1, m["ien"]);
      wr(3'h7, m["scr"]);
      wr(3'h2, 8'h01);
      rdc("intr enable", 3'h1, m["ien"]);
      rdc("scratch", 3'h7, m["scr"]);
    end
    rdc("line control", 3'h3, 8'h03);
    rdc("intr status", 3'h2, regsel_pkg::ISTAT_IDLE);
    u_host_bus.xfer(1'b1, 1'b1, 3'h7, ~m["scr"], q);
    rdc("unselected", 3'h7, m["scr"]);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    rdc("revision", 3'h0, REV);
    rdc("device id", 3'h1, DID);
    m["dlo"] = 1 + $urandom % 255;
    m["dhi"] = $urandom % 256;
    m["alt"] = $urandom % 256;
    m["frac"] = $urandom % 16;
    wr(3'h0, m["dlo"]);
    wr(3'h1, m["dhi"]);
    wr(3'h2, m["alt"]);
    rdc("divisor low", 3'h0, m["dlo"]);
    rdc("divisor high", 3'h1, m["dhi"]);
    rdc("alt function", 3'h2, m["alt"]);
    wr(3'h3, regsel_pkg::ENH_KEY);
    wr(3'h2, 8'h10);
    wr(3'h1, 8'h40);
    rdc("enh function", 3'h2, 8'h10);
    rdc("feature ctl", 3'h1, 8'h40);
    for (int i = 4; i < 8; i++) begin
      m[$sformatf("c%0d", i)] = 8'h10 | ($urandom % 256);
      wr(3'(i), m[$sformatf("c%0d", i)]);
    end
    for (int i = 4; i < 8; i++) begin
      rdc("flow char", 3'(i), m[$sformatf("c%0d", i)]);
    end
    `CHK("key no loop", 1'b0, loop_active)
    wr(3'h3, 8'h80);
    wr(3'h2, m["frac"]);
    rdc("fraction", 3'h2, m["frac"]);
    wr(3'h3, regsel_pkg::ENH_KEY);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h80);
    rdc("alt kept", 3'h2, m["alt"]);
    wr(3'h3, 8'h03);
    wr(3'h7, 8'h5A);
    rdc("fifo level", 3'h7, 8'h00);
    wr(3'h3, regsel_pkg::ENH_KEY);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    rdc("scratch kept", 3'h7, m["scr"]);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h02);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    for (int i = 0; i < 16; i++) begin
      wr(3'h4, 8'h10 | i);
      mi_n = 4'($urandom);
      repeat (5) @(posedge mclk);
      u_host_bus.xfer(1'b0, 1'b0, 3'h6, 8'h00, q);
      `CHK("loop modem", {i[3], i[2], i[0], i[1]}, q[7:4])
      `CHK("held", 4'hF, {tx_pin, rts_out_n, dtr_out_n, op2_out_n})
      `CHK("loop on", 1'b1, loop_active)
    end
    for (int i = 0; i < 3; i++) begin
      wait_line(5);
      sent.push_back($urandom % 256);
      wr(3'h0, sent[$]);
      wait_line(0);
      rdc("loop data", 3'h0, sent.pop_front());
    end
    wr(3'h4, 8'h0B);
    repeat (3) @(posedge mclk);
    `CHK("loop off", 3'h0, {loop_active, rts_out_n, dtr_out_n})
    `CHK("op2 out", 1'b0, op2_out_n)
    u_host_bus.xfer(1'b0, 1'b0, 3'h5, 8'h00, q);
    `CHK("no break", 1'b0, q[4])
    finish_test();
  end
endmodule
bind uart_regsel regsel_props u_regsel_props (.mclk(mclk), .sys_rst(sys_rst),
  .clk_en(clk_en), .chan_sel_n(chan_sel_n), .addr(addr), .rd_stb(rd_stb),
  .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .tx_pin(tx_pin),
  .rts_out_n(rts_out_n), .dtr_out_n(dtr_out_n), .loop_active(loop_active));

// file: uart_regsel.sv
// one uart channel: register select, loopback and modem pin routing
// Notes on behaviour
// (RULE1) modem control bit four selects loopback
// (RULE2) transmit shift output feeds receive shifter
// (RULE3) normal channel functions continue during loopback
// (RULE4) tx, rts, dtr pins held idle
// (RULE5) external modem inputs ignored in loopback
// (RULE6) no hardware flow control in loopback
// (RULE7) host keeps rx high during loopback
// (RULE8) own register set, channel select, address
// (RULE9) addr 0 is rx/tx holding when divisor off
// (RULE10) addr 0/1 divisor bytes when divisor on
// (RULE11) addr 2 alternate or fraction by enhanced bit
// (RULE12) zero divisor reads give revision and id
// (RULE13) addr 1 interrupt enable when divisor off
// (RULE14) addr 2 interrupt status read, fifo control write
// (RULE15) line, modem control and modem status
// (RULE16) addr 5 line status without key
// (RULE17) addr 7 scratch or level/mode select
// (RULE18) key access: trigger, feature, enhanced function
// (RULE19) key access: resume and pause characters
// (RULE20) loopback modem status from modem control bits
`timescale 1ns/1ns
module uart_regsel #(
  parameter logic [7:0] REVISION = 8'h01, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // host bus, all sampled synchronously
  input wire logic chan_sel_n,
  input wire logic [2:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // serial and modem pins, active low modem lines
  input wire logic rx_pin,
  input wire logic cts_in_n,
  input wire logic dsr_in_n,
  input wire logic carrier_detect_in_n,
  input wire logic ring_indicator_in_n,
  output logic tx_pin,
  output logic rts_out_n,
  output logic dtr_out_n,
  output logic op2_out_n,
  output logic loop_active
);
  logic [7:0] lctl_r, ien_r, mctl_r, scr_r, div_lo_r, div_hi_r;
  logic [7:0] alt_r, frac_r, fctl_r, efunc_r, emsel_r, fctrl_r, trig_r;
  logic [7:0] xon1_r, xon2_r, xoff1_r, xoff2_r;
  logic [7:0] rxh_r, lstat_r;
  logic [3:0] mdelta_r, mprev_r;
  logic [4:0] rx_s1_r, rx_s2_r;
  logic [7:0] rd_nxt;
  logic sel, key, div, zero_div, loop, rd_ev, wr_ev;
  logic tx_busy, tx_line, rx_done, rx_brk, tx_load_r;
  logic [7:0] rx_byte, tx_byte_r;
  logic [3:0] mstat_now;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] b);
    hit = (a == b);
  endfunction

  assign sel = !chan_sel_n; // [RULE8]
  assign rd_ev = sel && rd_stb;
  assign wr_ev = sel && wr_stb;
  assign key = lctl_r == regsel_pkg::ENH_KEY;
  assign div = lctl_r[regsel_pkg::LCTL_DIV_BIT] && !key;
  assign zero_div = div_lo_r == regsel_pkg::BYTE_ZERO &&
                    div_hi_r == regsel_pkg::BYTE_ZERO;
  assign loop = mctl_r[regsel_pkg::MCTL_LOOP_BIT]; // [RULE1]

  // pins sampled twice before use
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_s1_r <= 5'h1F;
      rx_s2_r <= 5'h1F;
    end else if (clk_en) begin
      rx_s1_r <= {ring_indicator_in_n, carrier_detect_in_n, dsr_in_n,
                  cts_in_n, rx_pin};
      rx_s2_r <= rx_s1_r;
    end
  end

  // status bits: cts, dsr, ri, cd (active high)
  always_comb begin
    if (loop) begin
      mstat_now = {mctl_r[regsel_pkg::MCTL_OUT2_BIT], // [RULE20]
                   mctl_r[regsel_pkg::MCTL_OUT1_BIT],
                   mctl_r[regsel_pkg::MCTL_DTR_BIT],
                   mctl_r[regsel_pkg::MCTL_RTS_BIT]}; // [RULE5]
    end else begin
      mstat_now = ~{rx_s2_r[3], rx_s2_r[4], rx_s2_r[2], rx_s2_r[1]};
    end
  end

  loop_serial #(.DIV_W(16)) u_ser (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .loop_en(loop), // [RULE3]
    .divisor({div_hi_r, div_lo_r}),
    .tx_load(tx_load_r),
    .tx_byte(tx_byte_r),
    .rx_pin_sync(rx_s2_r[0]), // [RULE7]
    .tx_busy(tx_busy),
    .tx_line(tx_line),
    .rx_done(rx_done),
    .rx_brk(rx_brk),
    .rx_byte(rx_byte)
  );

  // register writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lctl_r <= regsel_pkg::LCTL_RESET;
      {ien_r, mctl_r, scr_r, div_lo_r, div_hi_r} <= '0;
      {alt_r, frac_r, fctl_r, efunc_r, emsel_r, fctrl_r, trig_r} <= '0;
      {xon1_r, xon2_r, xoff1_r, xoff2_r} <= '0;
      tx_load_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else if (clk_en) begin
      tx_load_r <= 1'b0;
      if (wr_ev) begin
        if (hit(addr, regsel_pkg::ADDR_LCTL)) lctl_r <= wr_data; // [RULE15]
        else if (key) begin
          unique case (addr) // [RULE18] [RULE19]
            regsel_pkg::ADDR_DATA: trig_r <= wr_data;
            regsel_pkg::ADDR_IEN: fctl_r <= wr_data;
            regsel_pkg::ADDR_ISTAT: efunc_r <= wr_data;
            regsel_pkg::ADDR_MCTL: xon1_r <= wr_data;
            regsel_pkg::ADDR_LSTAT: xon2_r <= wr_data;
            regsel_pkg::ADDR_MSTAT: xoff1_r <= wr_data;
            default: xoff2_r <= wr_data;
          endcase
        end else begin
          unique case (addr)
            regsel_pkg::ADDR_DATA: begin
              if (div) div_lo_r <= wr_data; // [RULE10]
              else if (!tx_busy) begin
                tx_byte_r <= wr_data; // [RULE9]
                tx_load_r <= 1'b1;
              end
            end
            regsel_pkg::ADDR_IEN: begin
              if (div) div_hi_r <= wr_data; // [RULE10]
              else ien_r <= wr_data; // [RULE13]
            end
            regsel_pkg::ADDR_ISTAT: begin
              if (!div) fctrl_r <= wr_data; // [RULE14]
              else if (efunc_r[regsel_pkg::EFUNC_ENH_BIT])
                frac_r <= wr_data; // [RULE11]
              else alt_r <= wr_data; // [RULE11]
            end
            regsel_pkg::ADDR_MCTL: mctl_r <= wr_data; // [RULE15]
            regsel_pkg::ADDR_SCRATCH: begin
              if (fctl_r[regsel_pkg::FCTL_SEL_BIT]) emsel_r <= wr_data;
              else scr_r <= wr_data; // [RULE17]
            end
            default: ;
          endcase
        end
      end
    end
  end

  // receive holding, line status, modem deltas
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxh_r <= 8'h00;
      lstat_r <= regsel_pkg::LSTAT_RESET;
      mdelta_r <= 4'h0;
      mprev_r <= 4'h0;
    end else if (clk_en) begin
      mprev_r <= mstat_now;
      lstat_r[regsel_pkg::LSTAT_THRE_BIT] <= !tx_busy && !tx_load_r;
      lstat_r[regsel_pkg::LSTAT_TEMT_BIT] <= !tx_busy && !tx_load_r;
      if (rd_ev && !key && !lctl_r[regsel_pkg::LCTL_DIV_BIT] &&
          hit(addr, regsel_pkg::ADDR_DATA))
        lstat_r[regsel_pkg::LSTAT_READY_BIT] <= 1'b0;
      if (rd_ev && !key && hit(addr, regsel_pkg::ADDR_LSTAT))
        lstat_r[regsel_pkg::LSTAT_BREAK_BIT] <= 1'b0;
      if (rd_ev && hit(addr, regsel_pkg::ADDR_MSTAT) && !key)
        mdelta_r <= mprev_r ^ mstat_now;
      else
        mdelta_r <= mdelta_r | (mprev_r ^ mstat_now);
      if (rx_done) begin
        rxh_r <= rx_byte;
        lstat_r[regsel_pkg::LSTAT_READY_BIT] <= 1'b1;
        if (rx_brk) lstat_r[regsel_pkg::LSTAT_BREAK_BIT] <= 1'b1;
      end
    end
  end

  // read mux
  always_comb begin
    rd_nxt = 8'h00;
    if (hit(addr, regsel_pkg::ADDR_LCTL)) rd_nxt = lctl_r;
    else if (key) begin
      unique case (addr)
        regsel_pkg::ADDR_DATA: rd_nxt = {7'h00, lstat_r[0]};
        regsel_pkg::ADDR_IEN: rd_nxt = fctl_r;
        regsel_pkg::ADDR_ISTAT: rd_nxt = efunc_r;
        regsel_pkg::ADDR_MCTL: rd_nxt = xon1_r;
        regsel_pkg::ADDR_LSTAT: rd_nxt = xon2_r;
        regsel_pkg::ADDR_MSTAT: rd_nxt = xoff1_r;
        default: rd_nxt = xoff2_r;
      endcase
    end else begin
      unique case (addr)
        regsel_pkg::ADDR_DATA:
          rd_nxt = !div ? rxh_r : zero_div ? REVISION : div_lo_r; // [RULE12]
        regsel_pkg::ADDR_IEN:
          rd_nxt = !div ? ien_r : zero_div ? DEVICE_ID : div_hi_r;
        regsel_pkg::ADDR_ISTAT:
          rd_nxt = !div ? regsel_pkg::ISTAT_IDLE :
                   efunc_r[regsel_pkg::EFUNC_ENH_BIT] ? frac_r : alt_r;
        regsel_pkg::ADDR_MCTL: rd_nxt = mctl_r;
        regsel_pkg::ADDR_LSTAT: rd_nxt = lstat_r; // [RULE16]
        regsel_pkg::ADDR_MSTAT: rd_nxt = {mprev_r, mdelta_r};
        default:
          rd_nxt = fctl_r[regsel_pkg::FCTL_SEL_BIT] ?
                   {7'h00, lstat_r[0]} : scr_r; // [RULE17]
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      tx_pin <= regsel_pkg::TX_IDLE;
      rts_out_n <= regsel_pkg::MODEM_OUT_IDLE_N;
      dtr_out_n <= regsel_pkg::MODEM_OUT_IDLE_N;
      op2_out_n <= regsel_pkg::MODEM_OUT_IDLE_N;
      loop_active <= 1'b0;
    end else if (clk_en) begin
      if (rd_ev) rd_data <= rd_nxt;
      loop_active <= loop;
      tx_pin <= loop ? regsel_pkg::TX_IDLE : tx_line; // [RULE4]
      rts_out_n <= loop ? regsel_pkg::MODEM_OUT_IDLE_N :
                   !mctl_r[regsel_pkg::MCTL_RTS_BIT]; // [RULE4] [RULE6]
      dtr_out_n <= loop ? regsel_pkg::MODEM_OUT_IDLE_N :
                   !mctl_r[regsel_pkg::MCTL_DTR_BIT];
      op2_out_n <= loop ? regsel_pkg::MODEM_OUT_IDLE_N :
                   !mctl_r[regsel_pkg::MCTL_OUT2_BIT];
    end
  end
endmodule
